// >>> ccw_config_bank.v
// calibration coefficient words 0x0B to 0x11 (two low, five high) and first measurement setup word
// Behaviour
// - temp gain = word 0x11 bits 15:8 above word 0x0B bits 15:0.
// - temp curvature = word 0x11 bits 7:0 above word 0x0C.
// - word 0x0D: bits 7:0 sensor gain top, 15:8 sensor offset top.
// - word 0x0E: bits 7:0 offset drift top, 15:8 gain drift top.
// - word 0x0F: bits 7:0 gain drift curve, 15:8 offset drift curve.
// - word 0x10: bits 7:0 temp offset top, 15:8 sensor curvature top.
// - high byte carries sign; every joined 24-bit value is signed.
// - setup bits 2:0 pick first amp gain 6,12,20,30,40,60,80,120.
// - setup bits 5:3 pick second amp gain 1.1 to 1.8.
// - setup bit 6 inverts bridge chopper, giving negative gain.
// - setup bits 10:7 pick 12 to 18 bit conversion; 7 up unused.
// - coefficient words 0x0B to 0x11 reset to zero.
`timescale 1ns/10ps
`default_nettype none
`include "ccw_consts.vh"

module ccw_config_bank (
	// clock and reset
	input wire clk,
	input wire rst,
	// word access port
	input wire [5:0] regAddr,
	input wire regWrEn,
	input wire [15:0] regWrData,
	input wire regRdEn,
	output reg [15:0] regRdData,
	output reg regRdHit,
	// low words held in the lower part of the store
	input wire [15:0] sensOffsetLow,
	input wire [15:0] sensGainLow,
	input wire [15:0] gainDriftLow,
	input wire [15:0] offsetDriftLow,
	input wire [15:0] offsetDriftCurvLow,
	input wire [15:0] gainDriftCurvLow,
	input wire [15:0] sensCurvLow,
	input wire [15:0] tempOffsetLow,
	// joined signed coefficients
	output wire signed [23:0] tempGainCoef,
	output wire signed [23:0] tempCurvatureCoef,
	output wire signed [23:0] sensGainCoef,
	output wire signed [23:0] sensOffsetCoef,
	output wire signed [23:0] offsetDriftCoef,
	output wire signed [23:0] gainDriftCoef,
	output wire signed [23:0] gainDriftCurvature,
	output wire signed [23:0] offsetDriftCurvature,
	output wire signed [23:0] tempOffsetCoef,
	output wire signed [23:0] sensorCurvatureCoef,
	output wire [9:0] coefNeg,
	// front amplifier and converter setup
	output reg [15:0] measureSetupWordA,
	output reg [2:0] firstAmpGainSel,
	output reg [6:0] firstAmpGain,
	output reg [2:0] secondAmpGainSel,
	output reg [4:0] secondAmpGainTenths,
	output reg bridgeInvert,
	output reg [3:0] adcResCode,
	output reg [4:0] adcBits,
	output reg adcResInvalid
);

	// ****************************************************************
	// stored words
	// ****************************************************************
	// seven coefficient words and the setup word
	reg [15:0] tempGainLow_q;
	reg [15:0] tempCurvLow_q;
	reg [15:0] sensGainOffsetHigh_q;
	reg [15:0] driftCoefsHigh_q;
	reg [15:0] driftCurvHigh_q;
	reg [15:0] tempOffSensCurvHigh_q;
	reg [15:0] tempCurvGainHigh_q;
	reg [15:0] setupWord_q;

	// a write lands at the taking edge; decoded outputs follow an edge later
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tempGainLow_q <= `CCW_WORD_RESET;
			tempCurvLow_q <= `CCW_WORD_RESET;
			sensGainOffsetHigh_q <= `CCW_WORD_RESET;
			driftCoefsHigh_q <= `CCW_WORD_RESET;
			driftCurvHigh_q <= `CCW_WORD_RESET;
			tempOffSensCurvHigh_q <= `CCW_WORD_RESET;
			tempCurvGainHigh_q <= `CCW_WORD_RESET;
			setupWord_q <= `CCW_SETUP_RESET;
		end else if (regWrEn) begin
			case (regAddr)
				`CCW_ADDR_TEMP_GAIN_COEF_LOW: begin
					tempGainLow_q <= regWrData;
				end
				`CCW_ADDR_TEMP_CURVATURE_COEF_LOW: begin
					tempCurvLow_q <= regWrData;
				end
				`CCW_ADDR_SENSOR_GAIN_OFFSET_HIGH: begin
					sensGainOffsetHigh_q <= regWrData;
				end
				`CCW_ADDR_DRIFT_COEFS_HIGH: begin
					driftCoefsHigh_q <= regWrData;
				end
				`CCW_ADDR_DRIFT_CURVATURE_HIGH: begin
					driftCurvHigh_q <= regWrData;
				end
				`CCW_ADDR_TEMP_OFFSET_SENS_CURV_HIGH: begin
					tempOffSensCurvHigh_q <= regWrData;
				end
				`CCW_ADDR_TEMP_CURV_GAIN_HIGH: begin
					tempCurvGainHigh_q <= regWrData;
				end
				`CCW_ADDR_MEASURE_SETUP_WORD_A: begin
					setupWord_q <= regWrData;
				end
				default: begin
					// writes to other addresses are dropped
				end
			endcase
		end
	end

	// ****************************************************************
	// read back
	// ****************************************************************
	reg [15:0] rdMux;
	reg rdHitMux;

	// unmapped addresses read as zero and report no hit
	always @* begin
		rdMux = `CCW_READ_UNMAPPED;
		rdHitMux = 1'b1;
		case (regAddr)
			`CCW_ADDR_TEMP_GAIN_COEF_LOW: begin
				rdMux = tempGainLow_q;
			end
			`CCW_ADDR_TEMP_CURVATURE_COEF_LOW: begin
				rdMux = tempCurvLow_q;
			end
			`CCW_ADDR_SENSOR_GAIN_OFFSET_HIGH: begin
				rdMux = sensGainOffsetHigh_q;
			end
			`CCW_ADDR_DRIFT_COEFS_HIGH: begin
				rdMux = driftCoefsHigh_q;
			end
			`CCW_ADDR_DRIFT_CURVATURE_HIGH: begin
				rdMux = driftCurvHigh_q;
			end
			`CCW_ADDR_TEMP_OFFSET_SENS_CURV_HIGH: begin
				rdMux = tempOffSensCurvHigh_q;
			end
			`CCW_ADDR_TEMP_CURV_GAIN_HIGH: begin
				rdMux = tempCurvGainHigh_q;
			end
			`CCW_ADDR_MEASURE_SETUP_WORD_A: begin
				rdMux = setupWord_q;
			end
			default: begin
				rdMux = `CCW_READ_UNMAPPED;
				rdHitMux = 1'b0;
			end
		endcase
	end

	// read data shows the word as it stood before a same-cycle write
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			regRdData <= `CCW_READ_UNMAPPED;
			regRdHit <= 1'b0;
		end else if (regRdEn) begin
			regRdData <= rdMux;
			regRdHit <= rdHitMux;
		end else begin
			regRdHit <= 1'b0;
		end
	end

	// ****************************************************************
	// coefficient assembly
	// ****************************************************************
	// high byte of each pair sits above its low word; bit 23 is the sign
	// low words from the lower store are registered inside the joiner
	wire [15:0] joinLow [0:9];
	wire [7:0] joinHigh [0:9];

	assign joinLow[0] = tempGainLow_q;
	assign joinHigh[0] = tempCurvGainHigh_q[15:8];
	assign joinLow[1] = tempCurvLow_q;
	assign joinHigh[1] = tempCurvGainHigh_q[7:0];
	assign joinLow[2] = sensGainLow;
	assign joinHigh[2] = sensGainOffsetHigh_q[7:0];
	assign joinLow[3] = sensOffsetLow;
	assign joinHigh[3] = sensGainOffsetHigh_q[15:8];
	assign joinLow[4] = offsetDriftLow;
	assign joinHigh[4] = driftCoefsHigh_q[7:0];
	assign joinLow[5] = gainDriftLow;
	assign joinHigh[5] = driftCoefsHigh_q[15:8];
	assign joinLow[6] = gainDriftCurvLow;
	assign joinHigh[6] = driftCurvHigh_q[7:0];
	assign joinLow[7] = offsetDriftCurvLow;
	assign joinHigh[7] = driftCurvHigh_q[15:8];
	assign joinLow[8] = tempOffsetLow;
	assign joinHigh[8] = tempOffSensCurvHigh_q[7:0];
	assign joinLow[9] = sensCurvLow;
	assign joinHigh[9] = tempOffSensCurvHigh_q[15:8];

	wire signed [23:0] joined [0:9];

	// one joiner per coefficient keeps each coefficient on a flop
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi = gi + 1) begin : gJoin
			ccw_coef_join uJoin (
				.clk(clk),
				.rst(rst),
				.lowPart(joinLow[gi]),
				.highByte(joinHigh[gi]),
				.coef(joined[gi]),
				.coefNeg(coefNeg[gi])
			);
		end
	endgenerate

	assign tempGainCoef = joined[0];
	assign tempCurvatureCoef = joined[1];
	assign sensGainCoef = joined[2];
	assign sensOffsetCoef = joined[3];
	assign offsetDriftCoef = joined[4];
	assign gainDriftCoef = joined[5];
	assign gainDriftCurvature = joined[6];
	assign offsetDriftCurvature = joined[7];
	assign tempOffsetCoef = joined[8];
	assign sensorCurvatureCoef = joined[9];

	// ****************************************************************
	// front amplifier decode
	// ****************************************************************
	wire [2:0] stage1Code;
	wire [2:0] stage2Code;
	wire [3:0] resCode;
	reg [6:0] stage1Gain;

	assign stage1Code = setupWord_q[`CCW_STAGE1_HI:`CCW_STAGE1_LO];
	assign stage2Code = setupWord_q[`CCW_STAGE2_HI:`CCW_STAGE2_LO];
	assign resCode = setupWord_q[`CCW_RES_HI:`CCW_RES_LO];

	// first stage gains follow no formula, so they come from a table
	always @* begin
		stage1Gain = `CCW_STAGE1_GAIN_0;
		case (stage1Code)
			3'h0: stage1Gain = `CCW_STAGE1_GAIN_0;
			3'h1: stage1Gain = `CCW_STAGE1_GAIN_1;
			3'h2: stage1Gain = `CCW_STAGE1_GAIN_2;
			3'h3: stage1Gain = `CCW_STAGE1_GAIN_3;
			3'h4: stage1Gain = `CCW_STAGE1_GAIN_4;
			3'h5: stage1Gain = `CCW_STAGE1_GAIN_5;
			3'h6: stage1Gain = `CCW_STAGE1_GAIN_6;
			3'h7: stage1Gain = `CCW_STAGE1_GAIN_7;
			default: stage1Gain = `CCW_STAGE1_GAIN_0;
		endcase
	end

	// ****************************************************************
	// converter resolution
	// ****************************************************************
	// codes above six name no resolution
	wire resValid;

	assign resValid = (resCode <= `CCW_RES_CODE_MAX);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			// reset leaves the converter at its 12-bit setting
			measureSetupWordA <= `CCW_SETUP_RESET;
			firstAmpGainSel <= 3'h0;
			firstAmpGain <= `CCW_STAGE1_GAIN_0;
			secondAmpGainSel <= 3'h0;
			secondAmpGainTenths <= `CCW_STAGE2_TENTHS_BASE;
			bridgeInvert <= 1'b0;
			adcResCode <= 4'h0;
			adcBits <= `CCW_RES_BITS_RESET;
			adcResInvalid <= 1'b0;
		end else begin
			// decoded outputs are registered so the front end sees clean levels
			measureSetupWordA <= setupWord_q;
			firstAmpGainSel <= stage1Code;
			firstAmpGain <= stage1Gain;
			secondAmpGainSel <= stage2Code;
			// gain in tenths: 1.1 for code 0 up to 1.8 for code 7
			secondAmpGainTenths <= `CCW_STAGE2_TENTHS_BASE
				+ {2'h0, stage2Code};
			bridgeInvert <= setupWord_q[`CCW_POLARITY_BIT];
			adcResInvalid <= ~resValid;
			// an unassigned code leaves the last valid resolution in place
			if (resValid) begin
				adcResCode <= resCode;
				adcBits <= `CCW_RES_BITS_BASE + {1'b0, resCode};
			end else begin
				adcResCode <= adcResCode;
				adcBits <= adcBits;
			end
		end
	end

endmodule // ccw_config_bank

`default_nettype wire

// >>> ccw_consts.vh
// constants for the calibration coefficient and measurement setup word bank
`ifndef CCW_CONSTS_VH
`define CCW_CONSTS_VH

// ****************************************************************
// word addresses
// ****************************************************************
`define CCW_ADDR_W 6
`define CCW_ADDR_TEMP_GAIN_COEF_LOW 6'h0b
`define CCW_ADDR_TEMP_CURVATURE_COEF_LOW 6'h0c
`define CCW_ADDR_SENSOR_GAIN_OFFSET_HIGH 6'h0d
`define CCW_ADDR_DRIFT_COEFS_HIGH 6'h0e
`define CCW_ADDR_DRIFT_CURVATURE_HIGH 6'h0f
`define CCW_ADDR_TEMP_OFFSET_SENS_CURV_HIGH 6'h10
`define CCW_ADDR_TEMP_CURV_GAIN_HIGH 6'h11
`define CCW_ADDR_MEASURE_SETUP_WORD_A 6'h12

// ****************************************************************
// reset values
// ****************************************************************
`define CCW_WORD_RESET 16'h0000
`define CCW_SETUP_RESET 16'h0000
`define CCW_READ_UNMAPPED 16'h0000

// ****************************************************************
// field positions
// ****************************************************************
`define CCW_HIGH_BYTE_HI 15
`define CCW_HIGH_BYTE_LO 8
`define CCW_LOW_BYTE_HI 7
`define CCW_LOW_BYTE_LO 0
`define CCW_STAGE1_HI 2
`define CCW_STAGE1_LO 0
`define CCW_STAGE2_HI 5
`define CCW_STAGE2_LO 3
`define CCW_POLARITY_BIT 6
`define CCW_RES_HI 10
`define CCW_RES_LO 7

// ****************************************************************
// gain and resolution encodings
// ****************************************************************
`define CCW_STAGE1_GAIN_0 7'h06
`define CCW_STAGE1_GAIN_1 7'h0c
`define CCW_STAGE1_GAIN_2 7'h14
`define CCW_STAGE1_GAIN_3 7'h1e
`define CCW_STAGE1_GAIN_4 7'h28
`define CCW_STAGE1_GAIN_5 7'h3c
`define CCW_STAGE1_GAIN_6 7'h50
`define CCW_STAGE1_GAIN_7 7'h78
`define CCW_STAGE2_TENTHS_BASE 5'h0b
`define CCW_RES_BITS_BASE 5'h0c
`define CCW_RES_CODE_MAX 4'h6
`define CCW_RES_BITS_RESET 5'h0c

`endif

// >>> ccw_coef_join.v
// joins a low word and a signed high byte into one 24-bit coefficient
`timescale 1ns/10ps
`default_nettype none

module ccw_coef_join (
	// clock and reset
	input wire clk,
	input wire rst,
	// parts
	input wire [15:0] lowPart,
	input wire [7:0] highByte,
	// joined coefficient
	output reg signed [23:0] coef,
	output reg coefNeg
);

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			coef <= 24'sh000000;
			coefNeg <= 1'b0;
		end else begin
			coef <= $signed({highByte, lowPart});
			// high byte holds the sign of the whole value
			coefNeg <= highByte[7];
		end
	end

endmodule // ccw_coef_join

`default_nettype wire

// >>> ccw_bank_monitor.sv
// assertion checker for the coefficient and setup word bank
`timescale 1ns/10ps
`default_nettype none
module ccw_bank_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// word access port
	input wire logic [5:0] regAddr,
	input wire logic regWrEn,
	input wire logic [15:0] regWrData,
	input wire logic regRdEn,
	input wire logic [15:0] regRdData,
	input wire logic regRdHit,
	// coefficients
	input wire logic [15:0] tempOffsetLow,
	input wire logic signed [23:0] tempGainCoef,
	input wire logic signed [23:0] tempCurvatureCoef,
	input wire logic signed [23:0] sensGainCoef,
	input wire logic signed [23:0] sensOffsetCoef,
	input wire logic signed [23:0] offsetDriftCoef,
	input wire logic signed [23:0] gainDriftCoef,
	input wire logic signed [23:0] gainDriftCurvature,
	input wire logic signed [23:0] offsetDriftCurvature,
	input wire logic signed [23:0] tempOffsetCoef,
	input wire logic signed [23:0] sensorCurvatureCoef,
	input wire logic [9:0] coefNeg,
	// setup decode
	input wire logic [15:0] measureSetupWordA,
	input wire logic [2:0] firstAmpGainSel,
	input wire logic [2:0] secondAmpGainSel,
	input wire logic [4:0] secondAmpGainTenths,
	input wire logic bridgeInvert,
	input wire logic [3:0] adcResCode,
	input wire logic [4:0] adcBits,
	input wire logic adcResInvalid
);
	logic [1:0] up_q;
	logic mapped;
	assign mapped = regAddr >= 6'h0b && regAddr <= 6'h12;
	// counts edges since reset so $past never looks into reset
	always @(posedge clk or posedge rst) begin
		if (rst) up_q <= 2'h0;
		else if (up_q != 2'h3) up_q <= up_q + 2'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wrTop; regWrEn && regAddr == 6'h11; endsequence
	sequence s_wrSetup; regWrEn && regAddr == 6'h12; endsequence
	property p_topBytes;
		logic [15:0] d;
		(s_wrTop, d = regWrData) |=> ##1 tempGainCoef[23:16] == d[15:8]
			&& tempCurvatureCoef[23:16] == d[7:0];
	endproperty
	property p_setupCopy;
		logic [15:0] d;
		(s_wrSetup, d = regWrData) |=> ##1 measureSetupWordA == d;
	endproperty
	property p_stage1; firstAmpGainSel == measureSetupWordA[2:0]; endproperty
	property p_stage2;
		secondAmpGainSel == measureSetupWordA[5:3]
			&& secondAmpGainTenths == 5'h0b + {2'h0, secondAmpGainSel};
	endproperty
	property p_polarity; bridgeInvert == measureSetupWordA[6]; endproperty
	property p_resBits;
		adcBits == 5'h0c + {1'b0, adcResCode} && adcResCode <= 4'h6
			&& adcResInvalid == (measureSetupWordA[10:7] > 4'h6);
	endproperty
	property p_badHold;
		adcResInvalid ? $stable(adcResCode)
			: adcResCode == measureSetupWordA[10:7];
	endproperty
	property p_signs;
		coefNeg == {sensorCurvatureCoef[23], tempOffsetCoef[23],
			offsetDriftCurvature[23], gainDriftCurvature[23],
			gainDriftCoef[23], offsetDriftCoef[23], sensOffsetCoef[23],
			sensGainCoef[23], tempCurvatureCoef[23], tempGainCoef[23]};
	endproperty
	property p_lowTrack;
		up_q == 2'h3 |-> tempOffsetCoef[15:0] == $past(tempOffsetLow);
	endproperty
	property p_rdHit;
		up_q != 2'h0 |-> regRdHit == ($past(regRdEn) && $past(mapped));
	endproperty
	property p_rdUnmapped; regRdEn && !mapped |=> regRdData == 16'h0000;
	endproperty
	a_topBytes: assert property (p_topBytes)
		else $error("top bytes");
	a_setupCopy: assert property (p_setupCopy) else $error("setup");
	a_stage1: assert property (p_stage1) else $error("stage one");
	a_stage2: assert property (p_stage2) else $error("stage two");
	a_polarity: assert property (p_polarity) else $error("pol");
	a_resBits: assert property (p_resBits) else $error("res");
	a_badHold: assert property (p_badHold) else $error("bad res");
	a_signs: assert property (p_signs) else $error("signs");
	a_lowTrack: assert property (p_lowTrack) else $error("low");
	a_rdHit: assert property (p_rdHit) else $error("read hit");
	a_rdUnmapped: assert property (p_rdUnmapped) else $error("unmapped");
endmodule // ccw_bank_monitor
bind ccw_config_bank ccw_bank_monitor mon_u (.*);
`default_nettype wire

// >>> tb_ccw_config_bank.sv
// self-checking bench for the coefficient and setup word bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmpCount++; if ((a) !== (b)) begin badCount++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb_ccw_config_bank;
	typedef struct packed {
		logic [15:0] w;
		logic [6:0] g1;
		logic [4:0] g2;
		logic [4:0] bits;
		logic bad;
	} ccw_row_t;
	ccw_row_t rows [8] = '{
		'{16'h0038, 7'h06, 5'h12, 5'h0c, 1'b0},
		'{16'h00f1, 7'h0c, 5'h11, 5'h0d, 1'b0},
		'{16'h012a, 7'h14, 5'h10, 5'h0e, 1'b0},
		'{16'h01e3, 7'h1e, 5'h0f, 5'h0f, 1'b0},
		'{16'h021c, 7'h28, 5'h0e, 5'h10, 1'b0},
		'{16'h02d5, 7'h3c, 5'h0d, 5'h11, 1'b0},
		'{16'h030e, 7'h50, 5'h0c, 5'h12, 1'b0},
		'{16'hffc7, 7'h78, 5'h0b, 5'h12, 1'b1}};
	logic clk = 0, rst = 1, regWrEn = 0, regRdEn = 0;
	logic [5:0] regAddr = 6'h00, a;
	logic [15:0] regWrData = 16'h0000, lowIn = 16'h1234;
	logic [15:0] sensOffsetLow, sensGainLow, gainDriftLow, offsetDriftLow;
	logic [15:0] offsetDriftCurvLow, gainDriftCurvLow, sensCurvLow;
	logic [15:0] tempOffsetLow, regRdData, measureSetupWordA;
	logic signed [23:0] tempGainCoef, tempCurvatureCoef, sensGainCoef;
	logic signed [23:0] sensOffsetCoef, offsetDriftCoef, gainDriftCoef;
	logic signed [23:0] gainDriftCurvature, offsetDriftCurvature;
	logic signed [23:0] tempOffsetCoef, sensorCurvatureCoef;
	logic [9:0] coefNeg;
	logic [6:0] firstAmpGain;
	logic [4:0] secondAmpGainTenths, adcBits;
	logic [3:0] adcResCode;
	logic [2:0] firstAmpGainSel, secondAmpGainSel;
	logic regRdHit, bridgeInvert, adcResInvalid;
	int badCount = 0, cmpCount = 0;
	logic [17:0] gotRow, expRow;
	assign sensGainLow = lowIn + 16'h1;
	assign offsetDriftLow = lowIn + 16'h2;
	assign gainDriftCurvLow = lowIn + 16'h3;
	assign tempOffsetLow = lowIn + 16'h4;
	assign sensOffsetLow = lowIn + 16'h5;
	assign gainDriftLow = lowIn + 16'h6;
	assign offsetDriftCurvLow = lowIn + 16'h7;
	assign sensCurvLow = lowIn + 16'h8;
	ccw_config_bank dut_u (.*);
	always #12.5 clk = ~clk;
	task tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#2;
		end
	endtask
	task idle;
		regWrEn = 0;
		regRdEn = 0;
		tick(1);
	endtask
	// strobes stay up so back-to-back calls never toggle in one step
	task wr(input logic [5:0] ad, input logic [15:0] dd);
		regAddr = ad;
		regWrData = dd;
		regWrEn = 1;
		regRdEn = 0;
		tick(1);
	endtask
	task rd(input logic [5:0] ad);
		regAddr = ad;
		regRdEn = 1;
		regWrEn = 0;
		tick(1);
	endtask
	task testDone;
		$display("checks %0d mismatches %0d", cmpCount, badCount);
		if (badCount == 0 && cmpCount > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		repeat (20) @(posedge clk);
		#2 rst = 0;
		for (a = 6'h0b; a <= 6'h12; a++) begin
			rd(a);
			`CHK({regRdHit, regRdData}, 17'h10000)
		end
		idle;
		`CHK({tempGainCoef, tempCurvatureCoef}, 48'h0)
		`CHK({firstAmpGain, secondAmpGainTenths, adcBits}, 17'h0196c)
		$display("reset test done");
		foreach (rows[i]) begin
			wr(6'h12, rows[i].w);
			idle;
			gotRow = {firstAmpGain, secondAmpGainTenths, adcBits, adcResInvalid};
			expRow = {rows[i].g1, rows[i].g2, rows[i].bits, rows[i].bad};
			`CHK(gotRow, expRow)
			`CHK({secondAmpGainSel, firstAmpGainSel}, rows[i].w[5:0])
			`CHK(adcResCode, rows[i].bits[3:0] - 4'hc)
			`CHK(measureSetupWordA, rows[i].w)
			`CHK(bridgeInvert, rows[i].w[6])
			rd(6'h12);
			`CHK(regRdData, rows[i].w)
			idle;
		end
		$display("setup test done");
		for (a = 6'h0b; a <= 6'h11; a++) wr(a, {2'b10, a, 2'b01, a});
		idle;
		`CHK(tempGainCoef, 24'h918b4b)
		`CHK(tempCurvatureCoef, 24'h518c4c)
		`CHK(sensGainCoef, {8'h4d, lowIn + 16'h1})
		`CHK(sensOffsetCoef, {8'h8d, lowIn + 16'h5})
		`CHK(offsetDriftCoef, {8'h4e, lowIn + 16'h2})
		`CHK(gainDriftCoef, {8'h8e, lowIn + 16'h6})
		`CHK(gainDriftCurvature, {8'h4f, lowIn + 16'h3})
		`CHK(offsetDriftCurvature, {8'h8f, lowIn + 16'h7})
		`CHK(tempOffsetCoef, {8'h50, lowIn + 16'h4})
		`CHK(sensorCurvatureCoef, {8'h90, lowIn + 16'h8})
		`CHK(coefNeg, 10'h2a9)
		lowIn = 16'hfff0;
		tick(2);
		`CHK(tempOffsetCoef, 24'h50fff4)
		regAddr = 6'h0d;
		regWrData = 16'h0102;
		regWrEn = 1;
		regRdEn = 1;
		tick(1);
		`CHK(regRdData, 16'h8d4d)
		idle;
		rd(6'h0d);
		`CHK(regRdData, 16'h0102)
		idle;
		`CHK({sensOffsetCoef[23:16], sensGainCoef[23:16]}, 16'h0102)
		`CHK(coefNeg[3:2], 2'b00)
		$display("coefficient test done");
		wr(6'h0a, 16'hffff);
		wr(6'h13, 16'hffff);
		idle;
		rd(6'h0a);
		`CHK({regRdHit, regRdData}, 17'h00000)
		rd(6'h13);
		`CHK({regRdHit, regRdData}, 17'h00000)
		idle;
		rst = 1;
		tick(2);
		rst = 0;
		tick(1);
		rd(6'h11);
		`CHK({regRdHit, regRdData, coefNeg}, 27'h4000000)
		idle;
		$display("unmapped and reset test done");
		testDone;
	end
	initial begin
		repeat (3000) @(posedge clk);
		badCount++;
		testDone;
	end
endmodule // tb_ccw_config_bank
`default_nettype wire
